// [hw/pll_clock_generator_control.sv]
// Purpose: digital control of the crystal path, pll loop logic and
//          base clock selector with its register port
// Assumes: crystal and vco levels are sampled synchronously on mclk
// Notes:   8-bit registers on a plain strobe port, read data next cycle
`default_nettype none
// Notes on behaviour
// - base clock is crystal/2 or vco/2, picked by the select bit
// - crystal path runs only while the oscillator enable is high
// - reference clocks are buffered copies of the crystal clock
// - vco clock divided by programmed n gives the feedback clock
// - vco centre is l times nominal, range half to twice that
// - phase detector gives up/down pulses from feedback vs reference
// - lock detector compares frequencies, sets filter mode and lock
// - tracking bit clear in acquisition; tracking when bit set
// - automatic bit set lets the lock detector switch the filter mode
// - in automatic mode tracking bit is read-only, set by detector
// - in automatic mode lock bit follows the lock tolerances
// - with irq enable in automatic mode each lock toggle interrupts
// - automatic bit clear makes tracking bit a software control
// - in manual mode lock bit reads zero and no interrupts occur
// - vco select refused while pll off, no off while selected
// - clock switch holds output for three edges of each clock
// - n of zero acts as one; l of zero disables the pll
module pll_clock_generator_control #(
	parameter int HOLD = clkgen_pkg::HOLD_EDGES
) (
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       osc_enable_in,
	input  wire logic       xtal_level_in,
	input  wire logic       vco_level_in,
	input  wire logic [1:0] addr_in,
	input  wire logic [7:0] wr_data_in,
	input  wire logic       wr_en_in,
	input  wire logic       rd_en_in,
	output logic [7:0]      rd_data_out,
	output logic            crystal_clk_out,
	output logic            base_clk_out,
	output logic            vco_feedback_clk_out,
	output logic            pump_up_out,
	output logic            pump_down_out,
	output logic            filter_tracking_out,
	output logic            pll_active_out,
	output logic            pll_lock_irq_out
);
	// ===========================================================
	// register state
	logic       pll_irq_enable_r;
	logic       pll_irq_flag_r;
	logic       pll_power_on_r;
	logic       base_clk_select_r;
	logic       auto_bw_r;
	logic       tracking_sw_r;
	logic [3:0] feedback_divisor_n_r;
	logic [3:0] vco_range_l_r;
	logic       lock_prev_r;

	// ===========================================================
	// clock paths
	logic pll_ref_clk_r;
	logic final_ref_clk_r;
	logic ref_prev_r;
	logic vco_prev_r;
	logic fb_prev_r;
	logic xtal_prev_r;

	// ===========================================================
	// decode
	logic wr_ctl_w;
	logic wr_bw_w;
	logic wr_prg_w;
	logic new_on_w;
	logic new_bcs_w;
	logic on_chg_w;
	logic bcs_chg_w;
	logic l_zero_w;
	logic pll_en_w;
	logic bcs_ok_w;
	logic on_ok_w;
	logic ref_rise_w;
	logic fb_rise_w;
	logic vco_rise_w;
	logic vco_fall_w;
	logic xtal_rise_w;
	logic det_lock_w;
	logic det_track_w;
	logic lock_bit_w;
	logic track_bit_w;
	logic lock_tgl_w;
	logic [7:0] rd_mux_w;

	assign wr_ctl_w  = wr_en_in && addr_in == clkgen_pkg::OFS_CONTROL;
	assign wr_bw_w   = wr_en_in && addr_in == clkgen_pkg::OFS_BANDWIDTH;
	assign wr_prg_w  = wr_en_in && addr_in == clkgen_pkg::OFS_PROGRAM;
	assign new_on_w  = wr_data_in[clkgen_pkg::CTL_ON_BIT];
	assign new_bcs_w = wr_data_in[clkgen_pkg::CTL_BCS_BIT];
	assign on_chg_w  = new_on_w != pll_power_on_r;
	assign bcs_chg_w = new_bcs_w != base_clk_select_r;
	assign l_zero_w  = vco_range_l_r == 4'h0;
	assign pll_en_w  = pll_power_on_r && !l_zero_w && osc_enable_in;
	assign bcs_ok_w  = bcs_chg_w && !on_chg_w
		&& (!new_bcs_w || (pll_power_on_r && !l_zero_w));
	assign on_ok_w   = on_chg_w && !bcs_chg_w
		&& (new_on_w || !base_clk_select_r);

	// ===========================================================
	// control register
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			pll_irq_enable_r  <= 1'b0;
			pll_power_on_r    <= 1'b0;
			base_clk_select_r <= 1'b0;
		end
		else
		begin
			if (wr_ctl_w)
				pll_irq_enable_r <= wr_data_in[clkgen_pkg::CTL_IRQ_EN_BIT];
			if (wr_ctl_w && on_ok_w)
				pll_power_on_r <= new_on_w;
			if (l_zero_w)
				base_clk_select_r <= 1'b0;
			else if (wr_ctl_w && bcs_ok_w)
				base_clk_select_r <= new_bcs_w;
		end
	end

	// ===========================================================
	// bandwidth and program registers
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			auto_bw_r            <= clkgen_pkg::RST_AUTO;
			tracking_sw_r        <= 1'b0;
			feedback_divisor_n_r <= clkgen_pkg::RST_PROGRAM[7:4];
			vco_range_l_r        <= clkgen_pkg::RST_PROGRAM[3:0];
		end
		else
		begin
			if (wr_bw_w)
				auto_bw_r <= wr_data_in[clkgen_pkg::BW_AUTO_BIT];
			if (wr_bw_w && !auto_bw_r)
				tracking_sw_r <= wr_data_in[clkgen_pkg::BW_TRACK_BIT];
			if (wr_prg_w)
			begin
				feedback_divisor_n_r <=
					wr_data_in[clkgen_pkg::PRG_N_LSB +: 4];
				vco_range_l_r <= wr_data_in[clkgen_pkg::PRG_L_LSB +: 4];
			end
		end
	end

	// ===========================================================
	// oscillator and reference buffers
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			crystal_clk_out <= 1'b0;
			pll_ref_clk_r   <= 1'b0;
			final_ref_clk_r <= 1'b0;
			ref_prev_r      <= 1'b0;
			vco_prev_r      <= 1'b0;
			fb_prev_r       <= 1'b0;
			xtal_prev_r     <= 1'b0;
		end
		else
		begin
			crystal_clk_out <= xtal_level_in && osc_enable_in;
			pll_ref_clk_r   <= crystal_clk_out;
			final_ref_clk_r <= pll_ref_clk_r;
			ref_prev_r      <= final_ref_clk_r;
			vco_prev_r      <= vco_level_in && pll_en_w;
			fb_prev_r       <= vco_feedback_clk_out;
			xtal_prev_r     <= crystal_clk_out;
		end
	end

	assign ref_rise_w  = final_ref_clk_r && !ref_prev_r;
	assign fb_rise_w   = vco_feedback_clk_out && !fb_prev_r;
	assign vco_rise_w  = vco_level_in && pll_en_w && !vco_prev_r;
	assign vco_fall_w  = !(vco_level_in && pll_en_w) && vco_prev_r;
	assign xtal_rise_w = crystal_clk_out && !xtal_prev_r;

	// ===========================================================
	// feedback divider and lock detector
	// modulo divider
	fb_divider #(
		.W (4)
	) u_div (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.rise_in    (vco_rise_w),
		.fall_in    (vco_fall_w),
		.div_n_in   (feedback_divisor_n_r),
		.fb_clk_out (vco_feedback_clk_out)
	);

	lock_detect u_lock (
		.mclk_in     (mclk_in),
		.sys_rst_in  (sys_rst_in),
		.enable_in   (pll_en_w),
		.ref_rise_in (ref_rise_w),
		.fb_rise_in  (fb_rise_w),
		.lock_out    (det_lock_w),
		.track_out   (det_track_w)
	);

	assign lock_bit_w  = auto_bw_r && det_lock_w;
	assign track_bit_w = auto_bw_r ? det_track_w : tracking_sw_r;
	assign lock_tgl_w  = lock_bit_w != lock_prev_r;

	// ===========================================================
	// phase detector and filter mode
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in || !pll_en_w)
		begin
			pump_up_out         <= 1'b0;
			pump_down_out       <= 1'b0;
			filter_tracking_out <= 1'b0;
			pll_active_out      <= 1'b0;
		end
		else
		begin
			// up/down pulses, cleared once both edges seen
			if ((pump_up_out || ref_rise_w) && (pump_down_out || fb_rise_w))
			begin
				pump_up_out   <= 1'b0;
				pump_down_out <= 1'b0;
			end
			else
			begin
				pump_up_out   <= pump_up_out || ref_rise_w;
				pump_down_out <= pump_down_out || fb_rise_w;
			end
			filter_tracking_out <= track_bit_w;
			pll_active_out      <= 1'b1;
		end
	end

	// ===========================================================
	// lock change interrupt
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			lock_prev_r      <= 1'b0;
			pll_irq_flag_r   <= 1'b0;
			pll_lock_irq_out <= 1'b0;
		end
		else
		begin
			lock_prev_r <= lock_bit_w;
			// set on toggle; set wins over the read clear
			if (auto_bw_r && lock_tgl_w)
				pll_irq_flag_r <= 1'b1;
			else if (rd_en_in && addr_in == clkgen_pkg::OFS_CONTROL)
				pll_irq_flag_r <= 1'b0;
			pll_lock_irq_out <= pll_irq_flag_r && pll_irq_enable_r
				&& auto_bw_r;
		end
	end

	// ===========================================================
	// base clock selector with transition hold
	clkgen_pkg::switch_state_t sw_state_r;
	logic       sel_act_r;
	logic [1:0] old_cnt_r;
	logic [1:0] new_cnt_r;
	logic       old_rise_w;
	logic       new_rise_w;
	logic       act_rise_w;
	logic       old_dead_w;
	logic       hold_done_w;

	assign old_rise_w  = sel_act_r ? vco_rise_w : xtal_rise_w;
	assign new_rise_w  = sel_act_r ? xtal_rise_w : vco_rise_w;
	assign act_rise_w  = old_rise_w;
	// a stopped vco gives no rises; without this the hold never ends
	assign old_dead_w  = sel_act_r && !pll_en_w;
	assign hold_done_w = (old_cnt_r == 2'(HOLD) || old_dead_w)
		&& new_cnt_r == 2'(HOLD);

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			sw_state_r   <= clkgen_pkg::SW_IDLE;
			sel_act_r    <= 1'b0;
			old_cnt_r    <= 2'h0;
			new_cnt_r    <= 2'h0;
			base_clk_out <= 1'b0;
		end
		else
		begin
			case (sw_state_r)
				clkgen_pkg::SW_IDLE:
				begin
					if (act_rise_w)
						base_clk_out <= !base_clk_out;
					if (base_clk_select_r != sel_act_r)
					begin
						sw_state_r <= clkgen_pkg::SW_HOLD;
						old_cnt_r  <= 2'h0;
						new_cnt_r  <= 2'h0;
					end
				end
				clkgen_pkg::SW_HOLD:
				begin
					if (old_rise_w && old_cnt_r != 2'(HOLD))
						old_cnt_r <= old_cnt_r + 2'h1;
					if (new_rise_w && new_cnt_r != 2'(HOLD))
						new_cnt_r <= new_cnt_r + 2'h1;
					if (hold_done_w)
					begin
						sel_act_r  <= base_clk_select_r;
						sw_state_r <= clkgen_pkg::SW_IDLE;
					end
				end
				default:
					sw_state_r <= clkgen_pkg::SW_IDLE;
			endcase
		end
	end

	// ===========================================================
	// register read port
	always_comb
	begin
		rd_mux_w = 8'h00;
		case (addr_in)
			clkgen_pkg::OFS_CONTROL:
				rd_mux_w = {pll_irq_enable_r, pll_irq_flag_r,
					pll_power_on_r, base_clk_select_r,
					clkgen_pkg::CTL_LOW_READ};
			clkgen_pkg::OFS_BANDWIDTH:
				rd_mux_w = {auto_bw_r, lock_bit_w, track_bit_w, 5'h00};
			clkgen_pkg::OFS_PROGRAM:
				rd_mux_w = {feedback_divisor_n_r, vco_range_l_r};
			default:
				rd_mux_w = 8'h00;
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
			rd_data_out <= 8'h00;
		else
			rd_data_out <= rd_en_in ? rd_mux_w : 8'h00;
	end

	// ===========================================================
	// checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_hold_start;
		sw_state_r == clkgen_pkg::SW_IDLE && base_clk_select_r != sel_act_r;
	endsequence

	AST_BCS_NEEDS_ON: assert property (
		base_clk_select_r |-> pll_power_on_r)
		else $error("vco selected while pll off");
	AST_NO_SIMUL: assert property (
		wr_ctl_w && on_chg_w && bcs_chg_w && !l_zero_w |=>
		$stable(pll_power_on_r) && $stable(base_clk_select_r))
		else $error("power and select changed together");
	AST_L_ZERO: assert property (
		l_zero_w |=> !base_clk_select_r && !pll_active_out)
		else $error("range zero left pll usable");
	AST_HOLD_STATIC: assert property (
		s_hold_start |=> ##1 $stable(base_clk_out) [*2])
		else $error("base clock moved during hold");
	AST_OSC_GATE: assert property (
		!osc_enable_in |=> !crystal_clk_out)
		else $error("crystal out without enable");
	AST_REF_COPY: assert property (
		final_ref_clk_r == $past(crystal_clk_out, 2))
		else $error("reference not a crystal copy");
	AST_MANUAL_LOCK: assert property (
		!auto_bw_r |-> !lock_bit_w ##1 !pll_lock_irq_out)
		else $error("lock or irq active in manual");
	AST_IRQ_TOGGLE: assert property (
		auto_bw_r && lock_tgl_w && pll_irq_enable_r && !wr_en_in
		|=> ##1 pll_lock_irq_out)
		else $error("lock toggle raised no irq");
	AST_MANUAL_TRACK: assert property (
		wr_bw_w && !auto_bw_r && !wr_data_in[clkgen_pkg::BW_AUTO_BIT] |=>
		track_bit_w == $past(wr_data_in[clkgen_pkg::BW_TRACK_BIT]))
		else $error("manual tracking write lost");
endmodule
`default_nettype wire

// [inc/clkgen_pkg.sv]
// Purpose: shared constants of the clock generator control block
// Assumes: 8-bit register port, word index addressing
// Notes:   register offsets and bit positions are local choices
`default_nettype none
package clkgen_pkg;
	// ===========================================================
	// register map
	localparam logic [1:0] OFS_CONTROL   = 2'h0;
	localparam logic [1:0] OFS_BANDWIDTH = 2'h1;
	localparam logic [1:0] OFS_PROGRAM   = 2'h2;
	// ===========================================================
	// control register fields
	localparam int CTL_IRQ_EN_BIT = 7;
	localparam int CTL_FLAG_BIT   = 6;
	localparam int CTL_ON_BIT     = 5;
	localparam int CTL_BCS_BIT    = 4;
	localparam logic [3:0] CTL_LOW_READ = 4'hf;
	// ===========================================================
	// bandwidth register fields
	localparam int BW_AUTO_BIT  = 7;
	localparam int BW_LOCK_BIT  = 6;
	localparam int BW_TRACK_BIT = 5;
	// ===========================================================
	// program register fields: divisor high nibble, range low nibble
	localparam int PRG_N_LSB = 4;
	localparam int PRG_L_LSB = 0;
	// ===========================================================
	// reset values
	localparam logic [7:0] RST_PROGRAM = 8'h10;
	localparam logic       RST_AUTO    = 1'b0;
	// ===========================================================
	// timing and detector counts
	localparam int HOLD_EDGES = 3;
	localparam int LOCK_WIN   = 32;
	localparam int LOCK_TOL   = 1;
	localparam int UNL_TOL    = 3;
	localparam int TRK_TOL    = 2;
	localparam int UNT_TOL    = 4;
	// nominal vco centre step in tenths of a kHz, for software reference
	localparam int FNOM_KHZ_X10 = 49152;
	typedef enum logic [1:0] {SW_IDLE, SW_HOLD} switch_state_t;
endpackage
`default_nettype wire

// [hw/fb_divider.sv]
// Purpose: modulo divider on the sampled vco clock
// Assumes: vco level sampled on mclk, divisor zero acts as one
// Notes:   output rises once per n vco periods, falls on vco fall
`default_nettype none
module fb_divider #(
	parameter int W = 4
) (
	input  wire logic         mclk_in,
	input  wire logic         sys_rst_in,
	input  wire logic         rise_in,
	input  wire logic         fall_in,
	input  wire logic [W-1:0] div_n_in,
	output logic              fb_clk_out
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;
	logic [W-1:0] last_w;

	// a zero divisor is treated as one
	assign last_w  = (div_n_in == '0) ? '0 : div_n_in - W'(1);
	assign cnt_nxt = (cnt_r >= last_w) ? '0 : cnt_r + W'(1);

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			cnt_r      <= '0;
			fb_clk_out <= 1'b0;
		end
		else if (rise_in)
		begin
			cnt_r      <= cnt_nxt;
			fb_clk_out <= (cnt_r == '0);
		end
		else if (fall_in)
			fb_clk_out <= 1'b0;
	end
endmodule
`default_nettype wire

// [hw/lock_detect.sv]
// Purpose: frequency comparison of feedback against reference
// Assumes: one-cycle edge pulses on mclk
// Notes:   hysteresis: enter at tight tolerance, leave at wide one
`default_nettype none
module lock_detect #(
	parameter int WIN = clkgen_pkg::LOCK_WIN,
	parameter int LTL = clkgen_pkg::LOCK_TOL,
	parameter int UTL = clkgen_pkg::UNL_TOL,
	parameter int TTL = clkgen_pkg::TRK_TOL,
	parameter int XTL = clkgen_pkg::UNT_TOL
) (
	input  wire logic mclk_in,
	input  wire logic sys_rst_in,
	input  wire logic enable_in,
	input  wire logic ref_rise_in,
	input  wire logic fb_rise_in,
	output logic      lock_out,
	output logic      track_out
);
	localparam int CW = $clog2(4 * WIN + 1);
	logic [CW-1:0] ref_cnt_r;
	logic [CW-1:0] fb_cnt_r;
	logic [CW-1:0] diff_w;
	logic          done_w;

	assign done_w = ref_rise_in && (ref_cnt_r == CW'(WIN - 1));
	assign diff_w = (fb_cnt_r > CW'(WIN)) ? fb_cnt_r - CW'(WIN)
		: CW'(WIN) - fb_cnt_r;

	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in || !enable_in)
		begin
			ref_cnt_r <= '0;
			fb_cnt_r  <= '0;
			lock_out  <= 1'b0;
			track_out <= 1'b0;
		end
		else if (done_w)
		begin
			ref_cnt_r <= '0;
			fb_cnt_r  <= CW'(fb_rise_in);
			if (diff_w <= CW'(LTL))
				lock_out <= 1'b1;
			else if (diff_w > CW'(UTL))
				lock_out <= 1'b0;
			if (diff_w <= CW'(TTL))
				track_out <= 1'b1;
			else if (diff_w > CW'(XTL))
				track_out <= 1'b0;
		end
		else
		begin
			ref_cnt_r <= ref_cnt_r + CW'(ref_rise_in);
			if (fb_rise_in && fb_cnt_r != '1)
				fb_cnt_r <= fb_cnt_r + CW'(1);
		end
	end
endmodule
`default_nettype wire

// [sim/clk_source_model.sv]
// Purpose: crystal and vco level sources seen by the clock block
// Assumes: levels change just after the rising mclk edge
// Notes:   half periods in mclk cycles; a half period of zero acts as one
`default_nettype none
module clk_source_model (
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	input  wire logic [7:0] xhalf_in,
	input  wire logic [7:0] vhalf_in,
	output logic            xtal_level_out,
	output logic            vco_level_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] xcnt_r;
	logic [7:0] vcnt_r;
	wire        xwrap = (xcnt_r + 8'h01 >= xhalf_in);
	wire        vwrap = (vcnt_r + 8'h01 >= vhalf_in);
	// ==========================================================
	// free running sources; the bench retunes vco to pull lock
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			xcnt_r         <= 8'h00;
			vcnt_r         <= 8'h00;
			xtal_level_out <= 1'b0;
			vco_level_out  <= 1'b0;
		end
		else
		begin
			xcnt_r <= xwrap ? 8'h00 : xcnt_r + 8'h01;
			vcnt_r <= vwrap ? 8'h00 : vcnt_r + 8'h01;
			if (xwrap)
				xtal_level_out <= ~xtal_level_out;
			if (vwrap)
				vco_level_out <= ~vco_level_out;
		end
	end
endmodule
`default_nettype wire

// [sim/test_pll_clock_generator_control.sv]
// Purpose: self-checking bench for the clock generator control block
// Assumes: crystal and vco levels come from clk_source_model
// Notes:   edge counts are allowed one edge of slack at window ends
`default_nettype none
module test_pll_clock_generator_control;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] A_CTL = clkgen_pkg::OFS_CONTROL;
	localparam logic [1:0] A_BW  = clkgen_pkg::OFS_BANDWIDTH;
	localparam logic [1:0] A_PRG = clkgen_pkg::OFS_PROGRAM;
	logic       clk, rst, osc_en, xtal, vco, wr, rd;
	logic       crys, base, fb, pup, pdn, trk, act, irq, seen, unk;
	logic [1:0] addr;
	logic [3:0] dn;
	logic [7:0] wdata, rdata, xhalf, vhalf, lfsr, got;
	int         errors, n_tests, nx, nb, nv, nf, n;

	clk_source_model u_src (
		.mclk_in        (clk),
		.sys_rst_in     (rst),
		.xhalf_in       (xhalf),
		.vhalf_in       (vhalf),
		.xtal_level_out (xtal),
		.vco_level_out  (vco)
	);
	pll_clock_generator_control u_dut (
		.mclk_in              (clk),
		.sys_rst_in           (rst),
		.osc_enable_in        (osc_en),
		.xtal_level_in        (xtal),
		.vco_level_in         (vco),
		.addr_in              (addr),
		.wr_data_in           (wdata),
		.wr_en_in             (wr),
		.rd_en_in             (rd),
		.rd_data_out          (rdata),
		.crystal_clk_out      (crys),
		.base_clk_out         (base),
		.vco_feedback_clk_out (fb),
		.pump_up_out          (pup),
		.pump_down_out        (pdn),
		.filter_tracking_out  (trk),
		.pll_active_out       (act),
		.pll_lock_irq_out     (irq)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// ==========================================================
	// compare tasks
	task automatic check_reg(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic check_cnt(input string nm, input int e, input int g);
		n_tests++;
		if (unk || g < e - 1 || g > e + 1)
		begin
			errors++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	// ==========================================================
	// register port cycles
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic rd_chk(input string nm, input logic [1:0] a,
		input logic [7:0] e);
		reg_rd(a, got);
		check_reg(nm, e, got);
	endtask
	// polls with a bound; the caller compares the last value read
	task automatic wait_reg(input logic [1:0] a, input logic [7:0] e);
		int i;
		for (i = 0; i < 400; i++)
		begin
			reg_rd(a, got);
			if (got === e)
				break;
			repeat (16) @(posedge clk);
		end
	endtask
	// ==========================================================
	// edge counting on crystal, base, vco and feedback
	task automatic count_edges(input int cyc);
		logic [3:0] p;
		logic [3:0] c;
		nx = 0;
		nb = 0;
		nv = 0;
		nf = 0;
		unk = 1'b0;
		tick();
		p = {crys, base, vco, fb};
		repeat (cyc)
		begin
			tick();
			c = {crys, base, vco, fb};
			if ($isunknown(c)) unk = 1'b1;
			if (c[3] && !p[3]) nx++;
			if (c[2] && !p[2]) nb++;
			if (c[1] && !p[1]) nv++;
			if (c[0] && !p[0]) nf++;
			p = c;
		end
	endtask
	task automatic check_hold(input int cyc);
		logic b0;
		logic moved;
		tick();
		b0 = base;
		moved = 1'b0;
		repeat (cyc)
		begin
			tick();
			if (base !== b0) moved = 1'b1;
		end
		check_reg("base hold", 8'h00, {7'h00, moved});
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge clk);
		errors++;
		$display("watchdog expired");
		complete_run();
	end

	initial
	begin
		rst = 1'b1;
		osc_en = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 2'h0;
		wdata = 8'h00;
		xhalf = 8'h0c;
		vhalf = 8'h06;
		lfsr = 8'h58;
		errors = 0;
		n_tests = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		// ==========================================================
		// reset values and the unused index
		rd_chk("ctl rst", A_CTL, 8'h0f);
		rd_chk("bw rst", A_BW, 8'h00);
		rd_chk("prg rst", A_PRG, clkgen_pkg::RST_PROGRAM);
		lfsr = lfsr_next(lfsr);
		reg_wr(2'h3, lfsr);
		rd_chk("idx3", 2'h3, 8'h00);
		$display("test reset done");
		// ==========================================================
		// crystal path gated by the oscillator enable
		count_edges(240);
		check_cnt("xtal off", 0, nx);
		@(posedge clk);
		osc_en <= 1'b1;
		count_edges(240);
		check_cnt("xtal on", 10, nx);
		check_cnt("base xtal", 5, nb);
		$display("test crystal done");
		// ==========================================================
		// power and select refusals
		reg_wr(A_CTL, 8'h20);
		repeat (3) tick();
		check_reg("active l0", 8'h00, {7'h00, act});
		reg_wr(A_CTL, 8'h30);
		rd_chk("sel l0", A_CTL, 8'h2f);
		reg_wr(A_PRG, 8'h01);
		repeat (3) tick();
		check_reg("active", 8'h01, {7'h00, act});
		reg_wr(A_CTL, 8'h10);
		rd_chk("both", A_CTL, 8'h2f);
		$display("test refusals done");
		// ==========================================================
		// feedback divider over corner and random divisors
		for (n = 0; n < 5; n++)
		begin
			lfsr = lfsr_next(lfsr);
			dn = (n < 4) ? n[3:0] : lfsr[3:0];
			reg_wr(A_PRG, {dn, 4'h1});
			count_edges(480);
			check_cnt("fb", nv / ((dn == 4'h0) ? 1 : int'(dn)), nf);
		end
		$display("test divider done");
		// ==========================================================
		// manual mode bring-up and switch to the vco
		reg_wr(A_PRG, 8'h21);
		repeat (100) tick();
		reg_wr(A_BW, 8'h20);
		rd_chk("bw man", A_BW, 8'h20);
		check_reg("trk man", 8'h01, {7'h00, trk});
		repeat (100) tick();
		reg_wr(A_CTL, 8'h30);
		tick();
		check_hold(40);
		rd_chk("sel", A_CTL, 8'h3f);
		reg_wr(A_CTL, 8'h10);
		rd_chk("off sel", A_CTL, 8'h3f);
		repeat (200) tick();
		count_edges(480);
		check_cnt("base vco", nv / 2, nb);
		reg_wr(A_CTL, 8'hb0);
		repeat (1200) tick();
		rd_chk("lock man", A_BW, 8'h20);
		check_reg("irq man", 8'h00, {7'h00, irq});
		$display("test manual done");
		// ==========================================================
		// automatic mode: lock, flag, interrupt, unlock
		@(posedge clk);
		vhalf <= 8'h04;
		repeat (1200) tick();
		reg_wr(A_BW, 8'h80);
		wait_reg(A_BW, 8'h80);
		check_reg("bw unl", 8'h80, got);
		@(posedge clk);
		vhalf <= 8'h06;
		wait_reg(A_BW, 8'he0);
		check_reg("bw lock", 8'he0, got);
		repeat (4) tick();
		check_reg("irq lock", 8'h01, {7'h00, irq});
		rd_chk("flag", A_CTL, 8'hff);
		repeat (4) tick();
		check_reg("irq clr", 8'h00, {7'h00, irq});
		reg_wr(A_BW, 8'h80);
		rd_chk("trk ro", A_BW, 8'he0);
		check_reg("trk on", 8'h01, {7'h00, trk});
		@(posedge clk);
		vhalf <= 8'h04;
		wait_reg(A_BW, 8'h80);
		check_reg("bw unlock", 8'h80, got);
		repeat (4) tick();
		check_reg("irq unl", 8'h01, {7'h00, irq});
		check_reg("trk off", 8'h00, {7'h00, trk});
		seen = 1'b0;
		repeat (480)
		begin
			tick();
			if (pup === 1'b1 || pdn === 1'b1) seen = 1'b1;
		end
		check_reg("pump", 8'h01, {7'h00, seen});
		reg_wr(A_BW, 8'h00);
		repeat (4) tick();
		check_reg("irq off", 8'h00, {7'h00, irq});
		$display("test automatic done");
		complete_run();
	end
endmodule
`default_nettype wire
